// ===== src/tcct_timer.sv
// Functional notes
// RULE1 - three independent sixteen bit counters
// RULE2 - channels 0,1 up; channel 2 up/down phase
// RULE3 - counter advances on prescaler selected source
// RULE4 - clear on register A/B match or capture
// RULE5 - upward wrap sets channel overflow flag
// RULE6 - downward wrap sets same overflow flag
// RULE7 - word or byte bus access
// RULE8 - counters zero on reset and standby
// RULE9 - six general registers, compare or capture
// RULE10 - compare equality sets match flag
// RULE11 - drive selected compare output on match
// RULE12 - capture loads counter and sets flag
// RULE13 - capture only on selected valid edges
// RULE14 - pwm mode ignores io control settings
// RULE15 - general registers all ones, compare, no output
// RULE16 - control register top bit reads one
// RULE17 - phase mode ignores edge and prescaler fields
// RULE18 - clear field: none, A, B, synchronous
// RULE19 - edge field: rising, falling, both
// RULE20 - prescaler: internal divisions or external a..d
// RULE21 - control register resets to 0x80
// RULE22 - clear beats count in same cycle
// RULE23 - pins sampled and edge detected synchronously
`timescale 1ns/1ps
module tcct_timer
#(
  parameter int PRE_W = 3
)
(
  input  wire logic                            clk_sys,  // 20 MHz
  input  wire logic                            rst_n,    // sync reset
  input  wire logic                            standby,  // standby
  input  wire tcct_pkg::tcct_bus_s             bus,      // cpu access
  output logic      [15:0]                     bus_rdata, // read data
  input  wire logic [tcct_pkg::NCH-1:0][7:0]   io_ctrl,  // io control
  input  wire logic [tcct_pkg::NCH-1:0]        pwm_mode, // pwm select
  input  wire logic                            phase_count_enable, // ch2
  input  wire logic [tcct_pkg::NCH-1:0]        sync_mask, // sync group
  input  wire logic [tcct_pkg::NEXT-1:0]       ext_clock_in, // a..d
  input  wire logic [tcct_pkg::NCH-1:0]        cap_in_a, // capture a
  input  wire logic [tcct_pkg::NCH-1:0]        cap_in_b, // capture b
  output logic      [tcct_pkg::NCH-1:0]        cmp_out_a, // compare a
  output logic      [tcct_pkg::NCH-1:0]        cmp_out_b, // compare b
  output tcct_pkg::tcct_evt_s                  evt       // flag sets
);
  import tcct_pkg::*;

  // ==========================================================
  // declarations
  localparam int SW = NEXT + 2 * NCH;

  tcct_state_s          st_r;
  tcct_state_s          st_nxt;
  logic [PRE_W:0]       pre_tick;
  logic [SW-1:0]        pin_lvl;
  logic [SW-1:0]        pin_rise;
  logic [SW-1:0]        pin_fall;
  logic [NEXT-1:0]      ext_l;
  logic [NEXT-1:0]      ext_r;
  logic [NEXT-1:0]      ext_f;
  logic [NCH-1:0]       ca_r;
  logic [NCH-1:0]       ca_f;
  logic [NCH-1:0]       cb_r;
  logic [NCH-1:0]       cb_f;
  logic [NCH-1:0]       up;
  logic [NCH-1:0]       dn;
  logic [NCH-1:0]       hit_a;
  logic [NCH-1:0]       hit_b;
  logic [NCH-1:0]       cap_a;
  logic [NCH-1:0]       cap_b;
  logic [NCH-1:0]       clr_own;
  logic [NCH-1:0]       clr;
  logic [NCH-1:0][3:0]  wr_hit;

  if (PRE_W != 3)
  begin : g_chk
    $error("prescaler must offer exactly four internal rates");
  end

  // ==========================================================
  // helpers
  function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] wd,
                                         input logic [1:0]  be);
    merge = old;
    if (be[1])
      merge[15:8] = wd[15:8];
    if (be[0])
      merge[7:0] = wd[7:0];
  endfunction

  // valid capture edge for one io function
  function automatic logic cap_hit(input logic [2:0] io,
                                   input logic       r,
                                   input logic       f);
    cap_hit = 1'b0;
    if (io[2])
      cap_hit = io[1] ? (r | f) : (io[0] ? f : r);
  endfunction

  // ==========================================================
  // pin synchronisers and prescaler
  tcct_sync #(.W(SW)) u_sync
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({cap_in_b, cap_in_a, ext_clock_in}),
    .lvl     (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  tcct_prescale #(.DIV_W(PRE_W)) u_pre
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .standby (standby),
    .tick    (pre_tick)
  );

  // split synchronised pins
  assign ext_l = pin_lvl[NEXT-1:0];                  // RULE23
  assign ext_r = pin_rise[NEXT-1:0];                 // RULE23
  assign ext_f = pin_fall[NEXT-1:0];
  assign ca_r  = pin_rise[NEXT+NCH-1:NEXT];
  assign ca_f  = pin_fall[NEXT+NCH-1:NEXT];
  assign cb_r  = pin_rise[SW-1:NEXT+NCH];
  assign cb_f  = pin_fall[SW-1:NEXT+NCH];

  // ==========================================================
  // per channel event decode
  always_comb
  begin
    logic [2:0] psel;
    logic [1:0] keg;
    logic [2:0] ioa;
    logic [2:0] iob;
    logic       a;
    logic       b;
    psel = '0;
    keg = '0;
    ioa = '0;
    iob = '0;
    a = ext_l[EXT_A];
    b = ext_l[EXT_B];
    for (int i = 0; i < NCH; i++)
    begin
      psel = st_r.tcr[i][TPSC_HI:TPSC_LO];
      keg = st_r.tcr[i][CKEG_HI:CKEG_LO];
      // internal rates count falling edges only
      if (!psel[2])
        up[i] = pre_tick[psel[1:0]];                 // RULE20
      else if (keg[1])
        up[i] = ext_r[psel[1:0]] | ext_f[psel[1:0]]; // RULE19
      else if (keg[0])
        up[i] = ext_f[psel[1:0]];
      else
        up[i] = ext_r[psel[1:0]];                    // RULE3
      dn[i] = 1'b0;
      // quadrature decode replaces edge and prescaler fields
      if (i == PH_CH && phase_count_enable)          // RULE17
      begin
        up[i] = (ext_r[EXT_A] & ~b) | (ext_f[EXT_A] & b)
              | (ext_r[EXT_B] & a) | (ext_f[EXT_B] & ~a);
        dn[i] = (ext_r[EXT_A] & b) | (ext_f[EXT_A] & ~b)
              | (ext_r[EXT_B] & ~a) | (ext_f[EXT_B] & a);
      end
      // pwm leaves io control without effect
      ioa = pwm_mode[i] ? IO_NONE : io_ctrl[i][IOA_HI:IOA_LO]; // RULE14
      iob = pwm_mode[i] ? IO_NONE : io_ctrl[i][IOB_HI:IOB_LO];
      cap_a[i] = cap_hit(ioa, ca_r[i], ca_f[i]);     // RULE13
      cap_b[i] = cap_hit(iob, cb_r[i], cb_f[i]);
      hit_a[i] = !ioa[2] && st_r.cnt[i] == st_r.general_reg_a[i]; // RULE10
      hit_b[i] = !iob[2] && st_r.cnt[i] == st_r.general_reg_b[i];
      case (tcct_clr_e'(st_r.tcr[i][CCLR_HI:CCLR_LO])) // RULE18
        CLR_A:   clr_own[i] = hit_a[i] | cap_a[i];   // RULE4
        CLR_B:   clr_own[i] = hit_b[i] | cap_b[i];
        default: clr_own[i] = 1'b0;
      endcase
      for (int r = 0; r < 4; r++)
        wr_hit[i][r] = bus.wr && bus.addr[3:2] == 2'(i)
                       && bus.addr[1:0] == 2'(r);
    end
  end

  // synchronous clear follows any other member of the group
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      clr[i] = clr_own[i];
      if (st_r.tcr[i][CCLR_HI:CCLR_LO] == CLR_SYNC && sync_mask[i])
        clr[i] = |(clr_own & sync_mask);
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    logic [2:0] ioa;
    logic [2:0] iob;
    logic [1:0] slot;
    ioa = '0;
    iob = '0;
    slot = bus.addr[3:2];
    st_nxt = st_r;
    st_nxt.evt = '0;
    if (standby)
    begin
      // counters 0, general regs all ones, control 0x80
      st_nxt = ST_RST;                               // RULE15
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ioa = pwm_mode[i] ? IO_NONE : io_ctrl[i][IOA_HI:IOA_LO];
        iob = pwm_mode[i] ? IO_NONE : io_ctrl[i][IOB_HI:IOB_LO];
        // counter: write, then clear, then count
        if (wr_hit[i][REG_CNT])
          st_nxt.cnt[i] = merge(st_r.cnt[i], bus.wdata, bus.be); // RULE7
        else if (clr[i])
          st_nxt.cnt[i] = CNT_RST;                   // RULE22
        else if (up[i] && !dn[i])
        begin
          st_nxt.cnt[i] = st_r.cnt[i] + CNT_ONE;     // RULE1
          st_nxt.evt.ovf[i] = st_r.cnt[i] == CNT_MAX; // RULE5
        end
        else if (dn[i] && !up[i])
        begin
          st_nxt.cnt[i] = st_r.cnt[i] - CNT_ONE;     // RULE2
          st_nxt.evt.ovf[i] = st_r.cnt[i] == CNT_RST; // RULE6
        end
        // general registers: write wins over capture
        if (wr_hit[i][REG_GRA])
          st_nxt.general_reg_a[i] = merge(st_r.general_reg_a[i], bus.wdata, bus.be); // RULE9
        else if (cap_a[i])
          st_nxt.general_reg_a[i] = st_r.cnt[i];               // RULE12
        if (wr_hit[i][REG_GRB])
          st_nxt.general_reg_b[i] = merge(st_r.general_reg_b[i], bus.wdata, bus.be);
        else if (cap_b[i])
          st_nxt.general_reg_b[i] = st_r.cnt[i];
        st_nxt.evt.match_a[i] = hit_a[i] | cap_a[i];  // RULE12
        st_nxt.evt.match_b[i] = hit_b[i] | cap_b[i];
        // compare output actions
        if (hit_a[i])
          case (tcct_io_e'(ioa))                     // RULE11
            IO_LOW:  st_nxt.out_a[i] = 1'b0;
            IO_HIGH: st_nxt.out_a[i] = 1'b1;
            IO_TOG:  st_nxt.out_a[i] = ~st_r.out_a[i];
            default: st_nxt.out_a[i] = st_r.out_a[i];
          endcase
        if (hit_b[i])
          case (tcct_io_e'(iob))
            IO_LOW:  st_nxt.out_b[i] = 1'b0;
            IO_HIGH: st_nxt.out_b[i] = 1'b1;
            IO_TOG:  st_nxt.out_b[i] = ~st_r.out_b[i];
            default: st_nxt.out_b[i] = st_r.out_b[i];
          endcase
        // control register lives in the low byte
        if (wr_hit[i][REG_CTRL] && bus.be[0])
          st_nxt.tcr[i] = bus.wdata[6:0];            // RULE16
      end
      // read data, unmapped slot answers zero
      if (bus.rd)
      begin
        st_nxt.rdata = '0;
        if (slot < 2'(NCH))
          case (bus.addr[1:0])
            REG_CTRL: st_nxt.rdata = {BYTE_ZERO,
                                      TCR_FIX | {1'b0, st_r.tcr[slot]}};
            REG_CNT:  st_nxt.rdata = st_r.cnt[slot]; // RULE7
            REG_GRA:  st_nxt.rdata = st_r.general_reg_a[slot];
            REG_GRB:  st_nxt.rdata = st_r.general_reg_b[slot];
            default:  st_nxt.rdata = '0;
          endcase
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      st_r <= ST_RST;                                // RULE21
    else
      st_r <= st_nxt;                                // RULE8
  end

  // outputs straight from the state register
  assign bus_rdata = st_r.rdata;
  assign cmp_out_a = st_r.out_a;
  assign cmp_out_b = st_r.out_b;
  assign evt       = st_r.evt;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  cnt_wrap_up_a: assert property ( // RULE5
    !standby && up[0] && !clr[0] && !wr_hit[0][REG_CNT]
    && st_r.cnt[0] == CNT_MAX
    |=> evt.ovf[0] && st_r.cnt[0] == CNT_RST)
    else $error("upward wrap of channel 0 lost");

  cnt_wrap_dn_a: assert property ( // RULE6
    !standby && dn[PH_CH] && !up[PH_CH] && !clr[PH_CH]
    && !wr_hit[PH_CH][REG_CNT] && st_r.cnt[PH_CH] == CNT_RST
    |=> evt.ovf[PH_CH] && st_r.cnt[PH_CH] == CNT_MAX)
    else $error("downward wrap of channel 2 lost");

  up_only_a: assert property ( // RULE2
    !standby && !clr[1] && !wr_hit[1][REG_CNT]
    |=> st_r.cnt[1] == $past(st_r.cnt[1])
        || st_r.cnt[1] == $past(st_r.cnt[1]) + CNT_ONE)
    else $error("channel 1 counted other than up");

  clr_prio_a: assert property ( // RULE22
    !standby && clr[0] && up[0] && !wr_hit[0][REG_CNT]
    |=> st_r.cnt[0] == CNT_RST)
    else $error("count beat clear");

  capture_load_a: assert property ( // RULE12
    !standby && cap_a[0] && !wr_hit[0][REG_GRA]
    |=> st_r.general_reg_a[0] == $past(st_r.cnt[0]) && evt.match_a[0])
    else $error("capture did not load counter");

  edge_only_a: assert property ( // RULE13
    !standby && !cap_a[0] && !wr_hit[0][REG_GRA]
    |=> $stable(st_r.general_reg_a[0]))
    else $error("general register changed without cause");

  match_flag_a: assert property ( // RULE10
    !standby && !pwm_mode[0] && !io_ctrl[0][IOB_HI]
    && st_r.cnt[0] == st_r.general_reg_b[0]
    |=> evt.match_b[0])
    else $error("compare match flag missing");

  standby_clr_a: assert property ( // RULE8
    standby |=> st_r.cnt == '0 && st_r.general_reg_a[2] == GR_RST
                && st_r.tcr[1] == TCR_RST && !cmp_out_a[0])
    else $error("standby did not reinitialise");

  ctrl_read_a: assert property ( // RULE16
    !standby && bus.rd && bus.addr == {2'h0, REG_CTRL}
    |=> bus_rdata[15:7] == 9'h001)
    else $error("control register upper bits wrong");

  cov_ovf_c: cover property (evt.ovf[0]);
  cov_cap_c: cover property (cap_b[2] ##1 evt.match_b[2]);
  cov_phase_c: cover property (phase_count_enable && dn[PH_CH]);
  cov_sync_c: cover property (clr[1] && !clr_own[1]);
endmodule

// ===== src/tcct_pkg.sv
package tcct_pkg;

  // ==========================================================
  // sizes
  localparam int NCH  = 3;     // timer channels
  localparam int NEXT = 4;     // external clock inputs a..d
  localparam int CW   = 16;    // counter width

  // ==========================================================
  // register map: addr[3:2] is the channel slot, addr[1:0] the index
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_CNT  = 2'h1;
  localparam logic [1:0] REG_GRA  = 2'h2;
  localparam logic [1:0] REG_GRB  = 2'h3;

  // ==========================================================
  // values
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] GR_RST   = 16'hFFFF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [6:0]  TCR_RST  = 7'h00;    // writable bits 6..0
  localparam logic [7:0]  TCR_FIX  = 8'h80;    // bit 7 reads as one
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // ==========================================================
  // field positions of timer_control_reg and io_control_reg
  localparam int CCLR_HI = 6;
  localparam int CCLR_LO = 5;
  localparam int CKEG_HI = 4;
  localparam int CKEG_LO = 3;
  localparam int TPSC_HI = 2;
  localparam int TPSC_LO = 0;
  localparam int IOB_HI  = 6;
  localparam int IOB_LO  = 4;
  localparam int IOA_HI  = 2;
  localparam int IOA_LO  = 0;
  localparam int EXT_A   = 0;  // phase input a
  localparam int EXT_B   = 1;  // phase input b
  localparam int PH_CH   = 2;  // channel with phase counting

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_A    = 2'b01,
    CLR_B    = 2'b10,
    CLR_SYNC = 2'b11
  } tcct_clr_e;

  typedef enum logic [2:0] {
    IO_NONE  = 3'b000,
    IO_LOW   = 3'b001,
    IO_HIGH  = 3'b010,
    IO_TOG   = 3'b011,
    IO_CAP_R = 3'b100,
    IO_CAP_F = 3'b101,
    IO_CAP_B = 3'b110,
    IO_CAP_X = 3'b111
  } tcct_io_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [3:0]  addr;
    logic [1:0]  be;     // be[1] high byte, be[0] low byte
    logic [15:0] wdata;
  } tcct_bus_s;

  typedef struct packed {
    logic [NCH-1:0] match_a;
    logic [NCH-1:0] match_b;
    logic [NCH-1:0] ovf;
  } tcct_evt_s;

  typedef struct packed {
    logic [NCH-1:0][15:0] cnt;
    logic [NCH-1:0][15:0] general_reg_a;
    logic [NCH-1:0][15:0] general_reg_b;
    logic [NCH-1:0][6:0]  tcr;
    logic [NCH-1:0]       out_a;
    logic [NCH-1:0]       out_b;
    tcct_evt_s            evt;
    logic [15:0]          rdata;
  } tcct_state_s;

  localparam tcct_state_s ST_RST = '{cnt: '0, general_reg_a: {NCH{GR_RST}},
    general_reg_b: {NCH{GR_RST}}, tcr: {NCH{TCR_RST}}, out_a: '0, out_b: '0,
    evt: '0, rdata: '0};

endpackage

// ===== src/tcct_sync.sv
`timescale 1ns/1ps
module tcct_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk_sys,  // system clock
  input  wire logic         rst_n,    // sync reset
  input  wire logic [W-1:0] din,      // asynchronous pins
  output logic      [W-1:0] lvl,      // synchronised level
  output logic      [W-1:0] rise,     // rising edge pulse
  output logic      [W-1:0] fall      // falling edge pulse
);
  // ==========================================================
  // two stages of synchroniser, third stage for edge history
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tcct_sync_s;

  tcct_sync_s st_r;
  tcct_sync_s st_nxt;

  if (W < 1)
  begin : g_chk
    $error("tcct_sync width must be positive");
  end

  always_comb
  begin
    st_nxt = '{s1: din, s2: st_r.s1, s3: st_r.s2};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // edges compare stage 2 with stage 3 only
  assign lvl  = st_r.s2;
  assign rise = st_r.s2 & ~st_r.s3;
  assign fall = ~st_r.s2 & st_r.s3;
endmodule

// ===== src/tcct_prescale.sv
`timescale 1ns/1ps
module tcct_prescale
#(
  parameter int DIV_W = 3
)
(
  input  wire logic           clk_sys,  // system clock
  input  wire logic           rst_n,    // sync reset
  input  wire logic           standby,  // standby clear
  output logic      [DIV_W:0] tick      // pulse per 2**k cycles
);
  // ==========================================================
  // free running divider
  typedef struct packed {
    logic [DIV_W-1:0] div;
  } tcct_pre_s;

  tcct_pre_s st_r;
  tcct_pre_s st_nxt;

  if (DIV_W < 1)
  begin : g_chk
    $error("tcct_prescale needs at least one divider bit");
  end

  always_comb
  begin
    st_nxt.div = standby ? '0 : st_r.div + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ticks mark the falling edge of each divided clock
  assign tick[0] = 1'b1;
  for (genvar k = 1; k <= DIV_W; k++)
  begin : g_tick
    assign tick[k] = &st_r.div[k-1:0];
  end
endmodule

// ===== sim/tcct_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================
// cpu side of the internal register bus
module tcct_cpu_model
(
  input  wire logic           clk_sys,   // system clock
  input  wire logic [15:0]    bus_rdata, // read data
  output tcct_pkg::tcct_bus_s bus        // strobes, address, data
);
  import tcct_pkg::*;

  // bus idle from time zero
  initial
  begin
    bus = '0;
  end

  // one write, strobe held over exactly one rising edge
  task automatic wr(input logic [3:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    @(negedge clk_sys);
    bus.addr  = a;
    bus.be    = be;
    bus.wdata = d;
    bus.wr    = 1'b1;
    @(negedge clk_sys);
    bus.wr    = 1'b0;
    bus.wdata = ~d; // stale data is not left on the bus
  endtask

  // one word read, data taken after the edge that took the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    bus.addr = a;
    bus.be   = 2'b11;
    bus.rd   = 1'b1;
    @(negedge clk_sys);
    bus.rd   = 1'b0;
    d        = bus_rdata;
  endtask
endmodule

// ===== sim/three_channel_capture_compare_timer_test.sv
`timescale 1ns/1ps
module three_channel_capture_compare_timer_test;
  import tcct_pkg::*;

  // ==========================================================
  // signals
  logic                clk_sys;
  logic                rst_n;
  logic                standby;
  tcct_bus_s           bus;
  logic [15:0]         bus_rdata;
  logic [NCH-1:0][7:0] io_ctrl;
  logic                phase_count_enable;
  logic [NEXT-1:0]     ext_clock_in;
  logic [NCH-1:0]      cap_in_a;
  logic [NCH-1:0]      cap_in_b;
  logic [NCH-1:0]      pwm_mode;
  logic [NCH-1:0]      sync_mask;
  logic [NCH-1:0]      cmp_out_a;
  logic [NCH-1:0]      cmp_out_b;
  tcct_evt_s           evt;
  int                  n_mismatch = 0;
  int                  n_tests = 0;
  int                  n_ovf [NCH] = '{default: 0};
  int                  n_ma  [NCH] = '{default: 0};
  int                  n_mb  [NCH] = '{default: 0};
  logic [15:0]         v0;
  logic [15:0]         v1;

  // ==========================================================
  // design and bus partner
  tcct_timer i_tcct_timer (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .standby            (standby),
    .bus                (bus),
    .bus_rdata          (bus_rdata),
    .io_ctrl            (io_ctrl),
    .pwm_mode           (pwm_mode),
    .phase_count_enable (phase_count_enable),
    .sync_mask          (sync_mask),
    .ext_clock_in       (ext_clock_in),
    .cap_in_a           (cap_in_a),
    .cap_in_b           (cap_in_b),
    .cmp_out_a          (cmp_out_a),
    .cmp_out_b          (cmp_out_b),
    .evt                (evt)
  );

  tcct_cpu_model i_tcct_cpu_model (
    .clk_sys   (clk_sys),
    .bus_rdata (bus_rdata),
    .bus       (bus)
  );

  // ==========================================================
  // clock and event pulse counting
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (evt.ovf[c] === 1'b1)
        n_ovf[c]++;
      if (evt.match_a[c] === 1'b1)
        n_ma[c]++;
      if (evt.match_b[c] === 1'b1)
        n_mb[c]++;
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [3:0] ad(input int c, input logic [1:0] r);
    return {2'(c), r};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [3:0] a, input logic [1:0] be,
                   input logic [15:0] d);
    i_tcct_cpu_model.wr(a, be, d);
  endtask

  task automatic r(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_tcct_cpu_model.rd(a, d);
    chk(d, exp);
  endtask

  // pins take two edges to reach the edge detectors
  task automatic settle();
    repeat (5) @(negedge clk_sys);
  endtask

  task automatic pulse_ext(input int i, input int n);
    repeat (n)
    begin
      ext_clock_in[i] = 1'b1;
      settle();
      ext_clock_in[i] = 1'b0;
      settle();
    end
  endtask

  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // watchdog, run needs well under a thousand cycles
  initial
  begin
    #100000;
    n_mismatch++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end

  // ==========================================================
  // tests
  initial
  begin
    rst_n              = 1'b0;
    standby            = 1'b0;
    io_ctrl            = '0;
    phase_count_enable = 1'b0;
    ext_clock_in       = '0;
    cap_in_b           = '0;
    cap_in_a           = '0;
    pwm_mode           = '0;
    sync_mask          = '0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    // reset values of all channels, unmapped slot
    for (int c = 0; c < NCH; c++)
    begin
      r(ad(c, REG_CTRL), 16'h0080);
      r(ad(c, REG_GRA), 16'hFFFF);
      r(ad(c, REG_GRB), 16'hFFFF);
    end
    i_tcct_cpu_model.rd(ad(0, REG_CNT), v0);
    chk({15'h0000, v0 < 16'h0040}, 16'h0001);
    w(4'hD, 2'b11, 16'h5A5A);
    r(4'hD, 16'h0000);
    done_test("reset");
    // word and byte writes
    w(ad(0, REG_GRA), 2'b11, 16'h1234);
    w(ad(0, REG_GRA), 2'b01, 16'hAB56);
    r(ad(0, REG_GRA), 16'h1256);
    w(ad(0, REG_GRA), 2'b10, 16'h78CD);
    r(ad(0, REG_GRA), 16'h7856);
    done_test("bytes");
    // external clock a, rising then both edges, wrap up
    w(ad(0, REG_CTRL), 2'b11, 16'h0004);
    r(ad(0, REG_CTRL), 16'h0084);
    w(ad(0, REG_CNT), 2'b11, 16'h0010);
    pulse_ext(EXT_A, 3);
    r(ad(0, REG_CNT), 16'h0013);
    w(ad(0, REG_CTRL), 2'b01, 16'h0014);
    w(ad(0, REG_CNT), 2'b11, 16'hFFFE);
    pulse_ext(EXT_A, 1);
    r(ad(0, REG_CNT), 16'h0000);
    chk(16'(n_ovf[0]), 16'h0001);
    done_test("external");
    // compare match on a clears counter and sets output
    w(ad(1, REG_CTRL), 2'b01, 16'h0024);
    w(ad(1, REG_CNT), 2'b11, 16'h0000);
    w(ad(1, REG_GRA), 2'b11, 16'h0003);
    io_ctrl[1] = 8'h02;
    pulse_ext(EXT_A, 3);
    r(ad(1, REG_CNT), 16'h0000);
    chk(16'(n_ma[1]), 16'h0001);
    chk({15'h0000, cmp_out_a[1]}, 16'h0001);
    done_test("compare");
    // internal divisions over a 16 cycle span
    for (int k = 0; k < 4; k++)
    begin
      w(ad(2, REG_CTRL), 2'b01, 16'(k));
      i_tcct_cpu_model.rd(ad(2, REG_CNT), v0);
      repeat (14) @(negedge clk_sys);
      i_tcct_cpu_model.rd(ad(2, REG_CNT), v1);
      chk(v1 - v0, 16'(16 >> k));
    end
    done_test("prescaler");
    // phase counting, b leads a: one step down from zero
    phase_count_enable = 1'b1;
    w(ad(2, REG_CNT), 2'b11, 16'h0000);
    ext_clock_in[EXT_B] = 1'b1;
    settle();
    r(ad(2, REG_CNT), 16'hFFFF);
    chk(16'(n_ovf[2]), 16'h0001);
    done_test("phase");
    // capture on rising edge only into register b
    w(ad(2, REG_CNT), 2'b11, 16'h0055);
    repeat (3) @(negedge clk_sys);
    n_mb[2] = 0;
    io_ctrl[2] = 8'h40;
    cap_in_b[2] = 1'b1;
    settle();
    r(ad(2, REG_GRB), 16'h0055);
    chk(16'(n_mb[2]), 16'h0001);
    w(ad(2, REG_CNT), 2'b11, 16'h0066);
    cap_in_b[2] = 1'b0;
    settle();
    r(ad(2, REG_GRB), 16'h0055);
    chk(16'(n_mb[2]), 16'h0001);
    done_test("capture");
    // capture clears channel 0, channel 1 follows by sync clear
    w(ad(0, REG_CTRL), 2'b01, 16'h0024);
    w(ad(0, REG_CNT), 2'b11, 16'h0040);
    w(ad(0, REG_GRB), 2'b11, 16'h0042);
    w(ad(1, REG_CTRL), 2'b01, 16'h0064);
    w(ad(1, REG_CNT), 2'b11, 16'h0030);
    sync_mask = 3'b011;
    io_ctrl[0] = 8'h24;
    pulse_ext(EXT_A, 2);
    chk({15'h0000, cmp_out_b[0]}, 16'h0001);
    cap_in_a[0] = 1'b1;
    settle();
    r(ad(0, REG_GRA), 16'h0042);
    r(ad(0, REG_CNT), 16'h0000);
    r(ad(1, REG_CNT), 16'h0000);
    done_test("sync");
    // pwm mode leaves the capture edge without effect
    cap_in_a[0] = 1'b0;
    pwm_mode[0] = 1'b1;
    w(ad(0, REG_CNT), 2'b11, 16'h0077);
    cap_in_a[0] = 1'b1;
    settle();
    r(ad(0, REG_GRA), 16'h0042);
    r(ad(0, REG_CNT), 16'h0077);
    done_test("pwm");
    // standby reinitialises like reset
    standby = 1'b1;
    @(negedge clk_sys);
    standby = 1'b0;
    r(ad(0, REG_CTRL), 16'h0080);
    r(ad(0, REG_GRA), 16'hFFFF);
    r(ad(2, REG_GRB), 16'hFFFF);
    i_tcct_cpu_model.rd(ad(1, REG_CNT), v0);
    chk({15'h0000, v0 < 16'h0010}, 16'h0001);
    chk({15'h0000, cmp_out_b[0]}, 16'h0000);
    done_test("standby");
    report_and_stop();
  end
endmodule
